// ===== src/eewp_bit_if.sv
/*
  Decoded two-wire bus events passed from the line sampler to the
  protocol engine.
  Assumes both ends run on ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
interface eewp_bit_if;
  logic start_p;
  logic stop_p;
  logic rise_p;
  logic fall_p;
  logic sda_lvl;
  modport src (output start_p, output stop_p, output rise_p, output fall_p, output sda_lvl);
  modport dst (input start_p, input stop_p, input rise_p, input fall_p, input sda_lvl);
endinterface
`default_nettype wire

// ===== src/eewp_line_sync.sv
/*
  Samples the serial clock and data pins into the ref_clk domain and
  decodes clock edges, Start and Stop.
  Assumes the pins are asynchronous to ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module eewp_line_sync (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic scl_in,
  input  wire logic sda_in,
  eewp_bit_if.src   ev
);
  logic [2:0] scl_sh_q;
  logic [2:0] sda_sh_q;
  logic       scl_q;
  logic       sda_q;

  ////////////////////////////////////////////////////////////////////////////
  // A level is accepted once the second and third stages agree, so the
  // first stage feeds nothing but the second.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      scl_sh_q <= 3'h7;
      sda_sh_q <= 3'h7;
    end else begin
      scl_sh_q <= {scl_sh_q[1:0], scl_in};
      sda_sh_q <= {sda_sh_q[1:0], sda_in};
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      if (scl_sh_q[1] == scl_sh_q[2]) begin
        scl_q <= scl_sh_q[2];
      end
      if (sda_sh_q[1] == sda_sh_q[2]) begin
        sda_q <= sda_sh_q[2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic scl_new;
  logic sda_new;
  assign scl_new    = (scl_sh_q[1] == scl_sh_q[2]) ? scl_sh_q[2] : scl_q;
  assign sda_new    = (sda_sh_q[1] == sda_sh_q[2]) ? sda_sh_q[2] : sda_q;
  assign ev.rise_p  = scl_new & ~scl_q;
  assign ev.fall_p  = ~scl_new & scl_q;
  assign ev.start_p = scl_q & scl_new & sda_q & ~sda_new;
  assign ev.stop_p  = scl_q & scl_new & ~sda_q & sda_new;
  assign ev.sda_lvl = sda_new;
endmodule
`default_nettype wire

// ===== src/eewp_pkg.sv
/*
  Constants shared by the two-wire EEPROM target: array geometry, address
  byte layout, erased value and write cycle timing.
  Assumes a 200 MHz system clock.
*/
package eewp_pkg;
  localparam int unsigned ADDR_W         = 12;
  localparam int unsigned DATA_W         = 8;
  localparam int unsigned MEM_DEPTH      = 4096;
  localparam int unsigned PAGE_BYTES     = 32;
  localparam int unsigned PAGE_BITS      = 5;
  localparam logic [7:0]  ERASED_BYTE    = 8'hFF;
  localparam int unsigned RW_BIT_POS     = 0;
  localparam int unsigned TYPE_ID_POS    = 4;
  localparam int unsigned HW_SEL_POS     = 1;
  localparam int unsigned HI_ADDR_BITS   = 4;
  localparam int unsigned CLK_MHZ        = 200;
  localparam int unsigned WRITE_CYCLE_US = 5000;
  localparam int unsigned WRITE_CYCLES   = WRITE_CYCLE_US * CLK_MHZ;
endpackage

// ===== src/eewp_target.sv
/*
  Two-wire serial EEPROM target: address match, word address load, reads
  (current, random, sequential) and page writes with hardware protection.
  Assumes an external pull-up on the data line and a master clock far
  slower than ref_clk.
*/
// What this block does
// - Protect input high makes the whole array read-only.
// - Protect input low or open leaves writes fully enabled.
// - Protect input is sampled once at the Stop closing each write.
// - A launched programming cycle ignores later protect input changes.
// - Protected writes still acknowledge every byte but launch no cycle.
// - A rejected protected write leaves the device ready immediately.
// - Internal word counter holds last accessed address plus one; write increments roll over within the page.
// - Counter survives Start and Stop while powered.
// - Read increment wraps from the last byte to address zero.
// - Current-address read acknowledges then sends byte at counter.
// - Master no-acknowledge after a read byte ends the read.
// - Repeated Start with read address then returns the newly addressed byte.
// - Each read byte advances the address; master acknowledge sends the next byte.
// - Sequential read continues from either read kind while acknowledged.
// - Never-written locations read as FFh.
// - Bit zero of the address byte selects read when high.
// - Word address is twelve bits: low nibble of first byte, then second byte.
// - Mismatched address byte is not acknowledged; device returns to standby.
// - During a programming cycle the device ignores the bus entirely.
`timescale 1ns/1ps
`default_nettype none
module eewp_target #(
  parameter logic [3:0]  DEV_TYPE_ID = 4'h5,  // Arbitrary value.
  parameter int unsigned WR_CYCLES   = eewp_pkg::WRITE_CYCLES
) (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       wp_in,
  input  wire logic [2:0] hw_sel,
  output logic            busy
);
  localparam int unsigned AW = eewp_pkg::ADDR_W;
  localparam int unsigned DW = eewp_pkg::DATA_W;
  localparam int unsigned PB = eewp_pkg::PAGE_BITS;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_DEV   = 3'b001,
    ST_AHI   = 3'b010,
    ST_ALO   = 3'b011,
    ST_WDAT  = 3'b100,
    ST_RDAT  = 3'b101,
    ST_MACK  = 3'b110
  } eewp_state_e;

  eewp_bit_if ev ();

  eewp_line_sync u_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .scl_in  (scl_in),
    .sda_in  (sda_in),
    .ev      (ev)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Storage. Programming happens at the end of the write cycle so that a
  // page is committed as one unit.
  logic [DW-1:0]          mem_q [eewp_pkg::MEM_DEPTH];
  logic [DW-1:0]          page_q [eewp_pkg::PAGE_BYTES];
  logic [eewp_pkg::PAGE_BYTES-1:0] pvalid_q;
  logic [AW-PB-1:0]       prow_q;

  eewp_state_e            state_q;
  logic [3:0]             bit_q;
  logic [DW-1:0]          sh_q;
  logic                   ack_phase_q;
  logic                   ack_drv_q;
  logic                   is_read_q;
  logic [AW-1:0]          addr_q;
  logic [3:0]             ahi_q;
  logic                   wr_pend_q;
  logic                   prog_q;
  logic [31:0]            prog_cnt_q;
  logic                   dev_match_q;
  logic                   byte_done_q;
  logic [2:0]             wp_sh_q;
  logic                   wp_q;
  logic [eewp_pkg::MEM_DEPTH-1:0] written_q;
  logic [DW-1:0]          rd_byte;

  logic                   byte_done;
  logic [DW-1:0]          rx_byte;
  logic                   dev_match;

  assign byte_done = ev.rise_p && bit_q == 4'h7 && !ack_phase_q;
  assign rx_byte   = {sh_q[DW-2:0], ev.sda_lvl};
  assign dev_match = rx_byte[7:eewp_pkg::TYPE_ID_POS] == DEV_TYPE_ID
                     && rx_byte[3:eewp_pkg::HW_SEL_POS] == hw_sel;
  assign busy      = prog_q;
  assign rd_byte   = mem_rd(addr_q);

  ////////////////////////////////////////////////////////////////////////////
  // Protocol state. While programming, every bus event is dropped.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q     <= ST_IDLE;
      bit_q       <= 4'h0;
      sh_q        <= 8'h00;
      ack_phase_q <= 1'b0;
      is_read_q   <= 1'b0;
    end else if (prog_q) begin
      state_q     <= ST_IDLE;
      ack_phase_q <= 1'b0;
    end else if (ev.start_p) begin
      state_q     <= ST_DEV;
      bit_q       <= 4'h0;
      ack_phase_q <= 1'b0;
    end else if (ev.stop_p) begin
      state_q     <= ST_IDLE;
      ack_phase_q <= 1'b0;
    end else if (state_q != ST_IDLE) begin
      if (state_q == ST_RDAT) begin
        if (ev.fall_p && !ack_phase_q) begin
          sh_q  <= {sh_q[DW-2:0], 1'b0};
          bit_q <= (bit_q == 4'h7) ? 4'h0 : 4'(bit_q + 4'h1);
          if (bit_q == 4'h7) begin
            ack_phase_q <= 1'b1;
          end
        end else if (ev.rise_p && ack_phase_q) begin
          if (ev.sda_lvl) begin
            state_q <= ST_IDLE;
          end
        end else if (ev.fall_p && ack_phase_q) begin
          ack_phase_q <= 1'b0;
          sh_q        <= rd_byte;
        end
      end else if (byte_done) begin
        ack_phase_q <= 1'b1;
        bit_q       <= 4'h0;
        sh_q        <= rx_byte;
      end else if (ev.rise_p && !ack_phase_q) begin
        sh_q  <= rx_byte;
        bit_q <= 4'(bit_q + 4'h1);
      end else if (ev.fall_p && ack_phase_q && !byte_done_q) begin
        // The first fall after the eighth bit opens the acknowledge slot;
        // only the fall after the ninth clock closes it.
        ack_phase_q <= 1'b0;
        case (state_q)
          ST_DEV: begin
            if (!dev_match_q) begin
              state_q <= ST_IDLE;
            end else if (sh_q[eewp_pkg::RW_BIT_POS]) begin
              state_q   <= ST_RDAT;
              is_read_q <= 1'b1;
              sh_q      <= rd_byte;
            end else begin
              state_q   <= ST_AHI;
              is_read_q <= 1'b0;
            end
          end
          ST_AHI:  state_q <= ST_ALO;
          ST_ALO:  state_q <= ST_WDAT;
          ST_WDAT: state_q <= ST_WDAT;
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end

  // Match is latched at the eighth bit so the acknowledge slot drives it.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dev_match_q <= 1'b0;
    end else if (byte_done && state_q == ST_DEV) begin
      dev_match_q <= dev_match;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Word counter. It is only touched by bus traffic, never by Start or Stop.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      addr_q <= '0;
      ahi_q  <= 4'h0;
    end else if (!prog_q && byte_done) begin
      case (state_q)
        ST_AHI:  ahi_q  <= rx_byte[eewp_pkg::HI_ADDR_BITS-1:0];
        ST_ALO:  addr_q <= {ahi_q, rx_byte};
        ST_WDAT: addr_q <= {addr_q[AW-1:PB], 5'(addr_q[PB-1:0] + 5'h01)};
        default: addr_q <= addr_q;
      endcase
    end else if (!prog_q && state_q == ST_RDAT && ev.fall_p && !ack_phase_q
                 && bit_q == 4'h7) begin
      addr_q <= AW'(addr_q + 12'h001);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Page buffer collects data bytes of a write until Stop.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pvalid_q  <= '0;
      prow_q    <= '0;
      wr_pend_q <= 1'b0;
    end else if (prog_q || ev.start_p && state_q != ST_ALO) begin
      pvalid_q  <= prog_q ? pvalid_q : '0;
      wr_pend_q <= prog_q ? wr_pend_q : 1'b0;
    end else if (ev.stop_p) begin
      wr_pend_q <= 1'b0;
    end else if (byte_done && state_q == ST_WDAT) begin
      page_q[addr_q[PB-1:0]]   <= rx_byte;
      pvalid_q[addr_q[PB-1:0]] <= 1'b1;
      prow_q                   <= addr_q[AW-1:PB];
      wr_pend_q                <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Programming cycle. The protect level is looked at only in the Stop
  // cycle; afterwards nothing reads it, so it cannot abort the cycle.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prog_q     <= 1'b0;
      prog_cnt_q <= 32'h0000_0000;
    end else if (prog_q) begin
      if (prog_cnt_q == 32'(WR_CYCLES - 1)) begin
        prog_q <= 1'b0;
      end
      prog_cnt_q <= 32'(prog_cnt_q + 32'h1);
    end else if (ev.stop_p && wr_pend_q && !wp_q) begin
      prog_q     <= 1'b1;
      prog_cnt_q <= 32'h0000_0000;
    end
  end
  // A protected Stop simply leaves the buffer unused: no busy time at all.

  // The protect pin is asynchronous and passes the usual three stages.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wp_sh_q <= 3'h0;
      wp_q    <= 1'b0;
    end else begin
      wp_sh_q <= {wp_sh_q[1:0], wp_in};
      if (wp_sh_q[1] == wp_sh_q[2]) begin
        wp_q <= wp_sh_q[2];
      end
    end
  end

  // Erased array is all ones; there is no reset of the array itself.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      written_q <= '0;
    end else if (prog_q && prog_cnt_q == 32'(WR_CYCLES - 1)) begin
      for (int i = 0; i < eewp_pkg::PAGE_BYTES; i++) begin
        if (pvalid_q[i]) begin
          written_q[{prow_q, 5'(i)}] <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (prog_q && prog_cnt_q == 32'(WR_CYCLES - 1)) begin
      for (int i = 0; i < eewp_pkg::PAGE_BYTES; i++) begin
        if (pvalid_q[i]) begin
          mem_q[{prow_q, 5'(i)}] <= page_q[i];
        end
      end
    end
  end

  function automatic logic [DW-1:0] mem_rd(input logic [AW-1:0] a);
    mem_rd = written_q[a] ? mem_q[a] : eewp_pkg::ERASED_BYTE;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Data line drive, updated on falling clock so data is stable high.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ack_drv_q <= 1'b0;
    end else if (prog_q || ev.start_p || ev.stop_p) begin
      ack_drv_q <= 1'b0;
    end else if (ev.fall_p) begin
      if (state_q == ST_RDAT) begin
        ack_drv_q <= ack_phase_q ? !rd_byte[DW-1] : (bit_q == 4'h7 ? 1'b0 : !sh_q[DW-2]);
      end else if (state_q == ST_DEV && ack_phase_q && !byte_done_q) begin
        // A read address hands over the line with the first data bit.
        ack_drv_q <= dev_match_q && sh_q[eewp_pkg::RW_BIT_POS] && !rd_byte[DW-1];
      end else if (byte_done_q) begin
        ack_drv_q <= (state_q != ST_DEV) || dev_match_q;
      end else begin
        ack_drv_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      byte_done_q <= 1'b0;
    end else if (byte_done && state_q != ST_IDLE) begin
      byte_done_q <= 1'b1;
    end else if (ev.fall_p) begin
      byte_done_q <= 1'b0;
    end
  end

  // The pin is open drain: the level is fixed low and only the enable moves.
  assign sda_out = 1'b0;
  assign sda_oe  = ack_drv_q;
endmodule
`default_nettype wire

// ===== test/eewp_master_model.sv
/*
  Behavioural two-wire bus master that stands at the far side of the target.
  Assumes the bench resolves the data line with a pull-up from every enable.
*/
`timescale 1ns/1ps
`default_nettype none
module eewp_master_model (
  output logic      scl,
  output logic      sda_drv,
  input  wire logic sda
);
  localparam int Q = 12;
  // The serial clock idles high between frames and only runs inside them.
  initial begin
    scl = 1'b1;
    sda_drv = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic start();
    #Q sda_drv = 1'b0;
    #Q scl = 1'b1;
    #(2*Q) sda_drv = 1'b1;
    #(2*Q) scl = 1'b0;
  endtask
  task automatic stop();
    #Q sda_drv = 1'b1;
    #Q scl = 1'b1;
    #(2*Q) sda_drv = 1'b0;
    #(2*Q);
  endtask
  // Data is changed mid low phase and sampled mid high phase.
  task automatic bit_io(input logic b, output logic s);
    #Q sda_drv = ~b;
    #Q scl = 1'b1;
    #Q s = sda;
    #Q scl = 1'b0;
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
    end
    bit_io(1'b1, s);
    ack = (s === 1'b0);
  endtask
  task automatic recv(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(~ack, s);
  endtask
endmodule
`default_nettype wire

// ===== test/eewp_target_chk.sv
/*
  Concurrent checks on the ports of the two-wire EEPROM target.
  Assumes the pins are seen raw on ref_clk and the bus runs far slower.
*/
`timescale 1ns/1ps
`default_nettype none
module eewp_target_chk #(
  parameter int unsigned WR_CYCLES = 50
) (
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic       wp_in,
  input wire logic [2:0] hw_sel,
  input wire logic       busy
);
  logic        scl_q;
  logic        sda_q;
  logic        wp_stop_q;
  logic [7:0]  since_stop_q;
  logic [31:0] busy_len_q;
  logic        stop_seen;
  assign stop_seen = scl_q && scl_in && !sda_q && sda_in;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end
  // The protect level is held as seen at the last Stop on the wire.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      since_stop_q <= 8'hFF;
      wp_stop_q <= 1'b0;
    end else if (stop_seen) begin
      since_stop_q <= 8'h00;
      wp_stop_q <= wp_in;
    end else if (since_stop_q != 8'hFF) begin
      since_stop_q <= since_stop_q + 8'h01;
    end
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      busy_len_q <= 32'h0;
    end else begin
      busy_len_q <= busy ? busy_len_q + 32'h1 : 32'h0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  out_low_a: assert property (sda_out == 1'b0)
    else $error("data output not held low");
  cycle_at_stop_a: assert property ($rose(busy) |-> since_stop_q <= 8'h0C)
    else $error("write cycle began away from a Stop");
  wp_block_a: assert property ($rose(busy) |-> !wp_stop_q)
    else $error("write cycle began while protected");
  prot_idle_a: assert property (stop_seen && wp_in && !busy |=> !busy [*8])
    else $error("protected Stop launched a cycle");
  busy_hold_a: assert property ($rose(busy) |=> busy [*8])
    else $error("write cycle cut short");
  cycle_len_a: assert property ($fell(busy) |->
    (busy_len_q >= WR_CYCLES - 1) && (busy_len_q <= WR_CYCLES + 1))
    else $error("write cycle length wrong");
  busy_quiet_a: assert property (busy |-> !sda_oe)
    else $error("bus driven during write cycle");
  oe_on_low_a: assert property ($rose(sda_oe) |-> !$past(scl_in, 2))
    else $error("data line taken while clock high");
  cover property ($rose(busy));
  cover property (stop_seen && wp_in && !busy);
  cover property ($rose(sda_oe));
endmodule
bind eewp_target eewp_target_chk #(.WR_CYCLES(WR_CYCLES)) i_eewp_target_chk (
  .ref_clk(ref_clk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .wp_in(wp_in), .hw_sel(hw_sel), .busy(busy));
`default_nettype wire

// ===== test/test_serial_eeprom_read_and_write_protect.sv
/*
  Self-checking bench for the two-wire EEPROM target and its write protect.
  Assumes the master model drives the serial clock at a 48 ns period.
*/
`timescale 1ns/1ps
`default_nettype none
module test_serial_eeprom_read_and_write_protect;
  localparam logic [3:0] DEV_ID = 4'h5;  // Arbitrary value.
  localparam logic [2:0] SEL    = 3'h6;
  logic       ref_clk = 1'b0;
  logic       rst = 1'b1;
  logic       wp_in = 1'b0;
  logic [2:0] hw_sel = SEL;
  logic       scl;
  logic       m_drv;
  logic       sda_out;
  logic       sda_oe;
  logic       busy;
  wire logic  sda;
  int         err_count = 0;
  int         checked = 0;
  // Pull-up: the line is low only while some party pulls it.
  assign sda = ~(m_drv | (sda_oe & ~sda_out));
  always #2.5 ref_clk = ~ref_clk;
  eewp_target #(.DEV_TYPE_ID(DEV_ID), .WR_CYCLES(400)) i_eewp_target (
    .ref_clk(ref_clk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .wp_in(wp_in), .hw_sel(hw_sel), .busy(busy));
  eewp_master_model i_eewp_master_model (.scl(scl), .sda_drv(m_drv), .sda(sda));
  ////////////////////////////////////////////////////////////////////////////
  task automatic results();
    if (err_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  function automatic logic [7:0] dev(input logic rd);
    return {DEV_ID, SEL, rd};
  endfunction
  task automatic tx(input logic [7:0] d, input logic exp);
    logic a;
    i_eewp_master_model.send(d, a);
    chk_bit(a, exp);
  endtask
  task automatic rx(input logic [7:0] exp, input logic ack);
    logic [7:0] d;
    i_eewp_master_model.recv(ack, d);
    chk_byte(d, exp);
  endtask
  task automatic set_addr(input logic [11:0] a, input logic [3:0] junk);
    i_eewp_master_model.start();
    tx(dev(1'b0), 1'b1);
    tx({junk, a[11:8]}, 1'b1);
    tx(a[7:0], 1'b1);
  endtask
  task automatic rd_start();
    i_eewp_master_model.start();
    tx(dev(1'b1), 1'b1);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 1000) begin
      cycles(1);
      n++;
    end
    chk_bit(busy, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    cycles(1);
    chk_bit(busy, 1'b0);
    chk_bit(sda_oe, 1'b0);
  endtask
  // Two-byte page write, then a polled address while the cycle runs.
  task automatic t_write();
    set_addr(12'h000, 4'h0);
    tx(8'hA5, 1'b1);
    tx(8'h3C, 1'b1);
    i_eewp_master_model.stop();
    cycles(12);
    chk_bit(busy, 1'b1);
    cycles(90);
    @(posedge ref_clk) wp_in <= 1'b1;
    i_eewp_master_model.start();
    tx(dev(1'b0), 1'b0);
    i_eewp_master_model.stop();
    @(posedge ref_clk) wp_in <= 1'b0;
    wait_idle();
  endtask
  task automatic t_rand_seq();
    set_addr(12'hFFF, 4'hA);
    rd_start();
    rx(8'hFF, 1'b1);
    rx(8'hA5, 1'b0);
    i_eewp_master_model.stop();
  endtask
  task automatic t_mismatch();
    i_eewp_master_model.start();
    tx({DEV_ID, SEL ^ 3'h1, 1'b1}, 1'b0);
    i_eewp_master_model.stop();
    i_eewp_master_model.start();
    tx({DEV_ID ^ 4'h1, SEL, 1'b0}, 1'b0);
    i_eewp_master_model.stop();
  endtask
  task automatic t_current();
    rd_start();
    rx(8'h3C, 1'b1);
    rx(8'hFF, 1'b0);
    i_eewp_master_model.stop();
  endtask
  task automatic t_protect();
    @(posedge ref_clk) wp_in <= 1'b1;
    set_addr(12'h000, 4'h0);
    tx(8'h00, 1'b1);
    tx(8'h00, 1'b1);
    i_eewp_master_model.stop();
    cycles(12);
    chk_bit(busy, 1'b0);
    set_addr(12'h000, 4'h0);
    rd_start();
    rx(8'hA5, 1'b1);
    rx(8'h3C, 1'b0);
    i_eewp_master_model.stop();
    @(posedge ref_clk) wp_in <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    t_reset();
    t_write();
    t_rand_seq();
    t_mismatch();
    t_current();
    t_protect();
    results();
  end
  // The whole sequence needs about 15 us of bus time.
  initial begin
    #100000;
    err_count++;
    results();
  end
endmodule
`default_nettype wire
